/* bench/dgo_host.sv */
// Host controller model: register port master and load strobe driver.
// Assumes the block samples every input on the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
`include "dgo_map.svh"
module dgo_host (
   input wire logic mclk,
   output logic [`DGO_ADDR_W-1:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [31:0] bus_rdata,
   output logic load_converter_strobe
);
   initial begin
      bus_addr = '0;
      bus_wdata = '0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      load_converter_strobe = 1'b0;
   end

   // Any channel register may be rewritten at any time
   task automatic wr(input logic [`DGO_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [`DGO_ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      d = bus_rdata;
   endtask : rd

   task automatic ld();
      @(posedge mclk);
      load_converter_strobe <= 1'b1;
      @(posedge mclk);
      load_converter_strobe <= 1'b0;
   endtask : ld
endmodule : dgo_host
`default_nettype wire

/* bench/dgo_top_tb.sv */
// Self-checking bench for the calibration block.
// Assumes the host model drives all bus and load inputs.
`timescale 1ns/1ps
`default_nettype none
`include "dgo_map.svh"
module dgo_top_tb;
   import dgo_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [`DGO_ADDR_W-1:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic bus_wr;
   logic bus_rd;
   logic load_converter_strobe;
   logic busy_n;
   logic [`DGO_NUM_CH*`DGO_CODE_W-1:0] converter_codes;
   int err_count = 0;
   int checks = 0;

   always #20 mclk = ~mclk;

   dgo_top dgo_top_inst (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .load_converter_strobe(load_converter_strobe), .busy_n(busy_n),
      .converter_codes(converter_codes));
   dgo_host dgo_host_inst (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .load_converter_strobe(load_converter_strobe));

   function automatic dgo_code_t conv(input int i);
      return converter_codes[i*`DGO_CODE_W +: `DGO_CODE_W];
   endfunction : conv

   // Truncate the gain product first, then clamp the full result
   function automatic dgo_code_t model(input int x, input int g, input int c);
      int v;
      v = (((g + 1) * x) >>> `DGO_GAIN_SHIFT) + c - 8192;
      if (v > 16383) v = 16383;
      if (v < 0) v = 0;
      return dgo_code_t'(v);
   endfunction : model

   function automatic logic [`DGO_ADDR_W-1:0] adr(input logic [1:0] k, input int ch);
      return {k, 6'(ch), 2'h0};
   endfunction : adr

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp

   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge mclk);
      while (busy_n !== 1'b1 && n < 500) begin
         @(negedge mclk);
         n++;
      end
      if (busy_n !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: busy stuck, got %0h expected %0h", $time, busy_n, 1'b1);
         results();
      end
   endtask : wait_idle

   task automatic rd_code(input logic [1:0] k, input int ch, input dgo_code_t exp);
      logic [31:0] d;
      dgo_host_inst.rd(adr(k, ch), d);
      cmp(d, 32'(exp));
   endtask : rd_code

   task automatic settle_load();
      dgo_host_inst.ld();
      repeat (2) @(negedge mclk);
   endtask : settle_load

   task automatic t_reset();
      for (int i = 0; i < `DGO_NUM_CH; i++) cmp(32'(conv(i)), 32'h2000);
      rd_code(2'h0, 39, model(14'h2000, 13'h1FFF, 14'h2000));
      cmp(32'(busy_n), 32'h1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_calc();
      dgo_code_t e;
      e = model(32'h3000, 32'h1000, 32'h2100);
      dgo_host_inst.wr(adr(2'h1, 0), 32'h1000);
      dgo_host_inst.wr(adr(2'h2, 0), 32'h2100);
      dgo_host_inst.wr(adr(2'h0, 0), 32'h3000);
      @(negedge mclk);
      cmp(32'(busy_n), 32'h0);
      wait_idle();
      rd_code(2'h1, 0, e);
      rd_code(2'h0, 1, 14'h2000);
      rd_code(2'h0, 10, 14'h2000);
      cmp(32'(conv(0)), 32'h2000);
      settle_load();
      cmp(32'(conv(0)), 32'(e));
      cmp(32'(conv(1)), 32'h2000);
      $display("test calc done");
   endtask : t_calc

   task automatic t_clamp();
      dgo_host_inst.wr(adr(2'h2, 39), 32'h2001);
      dgo_host_inst.wr(adr(2'h0, 39), 32'h3FFF);
      dgo_host_inst.wr(adr(2'h2, 10), 32'h1FFF);
      dgo_host_inst.wr(adr(2'h0, 10), 32'h0);
      wait_idle();
      rd_code(2'h0, 39, model(16383, 8191, 8193));
      rd_code(2'h2, 10, model(0, 8191, 8191));
      settle_load();
      cmp(32'(conv(39)), 32'h3FFF);
      cmp(32'(conv(10)), 32'h0);
      $display("test clamp done");
   endtask : t_clamp

   task automatic t_defer();
      logic [31:0] s;
      for (int i = 3; i < 6; i++) dgo_host_inst.wr(adr(2'h0, i), 32'(i * 32'h0111));
      dgo_host_inst.ld();
      dgo_host_inst.rd(adr(2'h3, 0), s);
      cmp(32'(s[2:1]), 32'h2);
      cmp(32'(conv(3)), 32'h2000);
      wait_idle();
      repeat (2) @(negedge mclk);
      for (int i = 3; i < 6; i++) cmp(32'(conv(i)), 32'(model(i * 273, 8191, 8192)));
      dgo_host_inst.rd(adr(2'h3, 0), s);
      cmp(32'(s[2:1]), 32'h1);
      $display("test deferred load done");
   endtask : t_defer

   task automatic t_range();
      dgo_host_inst.wr(adr(2'h0, 45), 32'h0);
      @(negedge mclk);
      cmp(32'(busy_n), 32'h1);
      dgo_host_inst.wr(adr(2'h0, 20), 32'h1);
      wait_idle();
      dgo_host_inst.wr(adr(2'h3, 0), 32'h1);
      repeat (2) @(negedge mclk);
      cmp(32'(conv(20)), 32'(model(1, 8191, 8192)));
      cmp(32'(conv(39)), 32'h3FFF);
      $display("test range done");
   endtask : t_range

   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_calc();
      t_clamp();
      t_defer();
      t_range();
      results();
   end
endmodule : dgo_top_tb
`default_nettype wire

/* src/dgo_calc.sv */
// Pure transfer function with clamp, registered result.
// Assumes inputs stable in the cycle that start is high.
`timescale 1ns/1ps
`default_nettype none
`include "dgo_map.svh"
module dgo_calc (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire dgo_pkg::dgo_code_t code_in,
   input wire dgo_pkg::dgo_gain_t gain_in,
   input wire dgo_pkg::dgo_code_t offs_in,
   output logic done,
   output dgo_pkg::dgo_code_t result
);
   import dgo_pkg::*;
   // Wide signed math: 14x14 product plus offset never overflows 30 bits
   logic signed [29:0] prod;
   logic signed [29:0] scaled;
   logic signed [29:0] total;
   logic [13:0] clamped;
   assign prod = $signed({16'h0000, code_in}) * $signed({16'h0000, {1'b0, gain_in} + 14'h0001});
   assign scaled = prod >>> `DGO_GAIN_SHIFT;
   assign total = scaled + $signed({16'h0000, offs_in}) - $signed(30'h0000_2000);
   assign clamped = total < 0 ? 14'h0000 :
      (total > $signed({16'h0000, `DGO_FULL_SCALE}) ? `DGO_FULL_SCALE : total[13:0]);
   always_ff @(posedge mclk) begin
      if (rst) begin
         done <= 1'b0;
         result <= `DGO_CODE_RST;
      end else begin
         done <= start;
         if (start) begin
            result <= clamped;
         end
      end
   end
endmodule : dgo_calc
`default_nettype wire

/* src/dgo_map.svh */
// Register map, field widths, reset values and gain scaling for the channel calibration block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef DGO_MAP_SVH
`define DGO_MAP_SVH
`define DGO_NUM_CH 40
`define DGO_GROUP_SIZE 10
`define DGO_CODE_W 14
`define DGO_GAIN_W 13
`define DGO_CODE_RST 14'h2000
`define DGO_GAIN_RST 13'h1FFF
`define DGO_OFFS_RST 14'h2000
`define DGO_FULL_SCALE 14'h3FFF
`define DGO_GAIN_SHIFT 13
// Byte address: [9:8] register kind, [7:2] channel
`define DGO_KIND_INPUT 2'h0
`define DGO_KIND_GAIN 2'h1
`define DGO_KIND_OFFS 2'h2
`define DGO_KIND_CTRL 2'h3
`define DGO_ADDR_W 10
// Control/status word at kind 3, channel field 0
`define DGO_CTRL_LOAD_BIT 0
`define DGO_STAT_BUSY_N_BIT 1
`define DGO_STAT_PEND_BIT 2
`endif

/* src/dgo_mem.sv */
// Small per-channel register array with registered read and sync write.
// Assumes one write and one read port, reset value loaded into every entry at once while rst is high.
`timescale 1ns/1ps
`default_nettype none
module dgo_mem #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 40,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [5:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   initial begin
      if (DEPTH > 64) $error("dgo_mem depth too large");
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= RST_VAL;
         rdata <= RST_VAL;
      end else begin
         if (we && waddr < 6'(DEPTH)) mem_q[waddr] <= wdata;
         rdata <= raddr < 6'(DEPTH) ? mem_q[raddr] : RST_VAL;
      end
   end
endmodule : dgo_mem
`default_nettype wire

/* src/dgo_pkg.sv */
// Types shared by the calibration datapath files.
// Assumes dgo_map.svh is on the include path.
`include "dgo_map.svh"
package dgo_pkg;
   typedef logic [`DGO_CODE_W-1:0] dgo_code_t;
   typedef logic [`DGO_GAIN_W-1:0] dgo_gain_t;
   typedef struct packed {
      logic [`DGO_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dgo_bus_req_t;
   typedef enum logic [1:0] {
      DGO_K_INPUT = 2'h0,
      DGO_K_GAIN = 2'h1,
      DGO_K_OFFS = 2'h2,
      DGO_K_CTRL = 2'h3
   } dgo_kind_t;
endpackage : dgo_pkg

/* src/dgo_top.sv */
// Forty-channel gain/offset calibration with deferred converter load.
// Assumes a single-cycle strobed register port and a synchronous load strobe.
`timescale 1ns/1ps
`default_nettype none
`include "dgo_map.svh"
module dgo_top #(
   parameter int NUM_CH = `DGO_NUM_CH,
   parameter int GROUP_SIZE = `DGO_GROUP_SIZE
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [`DGO_ADDR_W-1:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic load_converter_strobe,
   output logic busy_n,
   output logic [NUM_CH*`DGO_CODE_W-1:0] converter_codes
);
   import dgo_pkg::*;
   initial begin
      if (NUM_CH < 1 || NUM_CH > 64) $error("NUM_CH out of range");
      if (GROUP_SIZE < 1 || NUM_CH % GROUP_SIZE != 0) $error("GROUP_SIZE must divide NUM_CH");
   end

   function automatic logic [5:0] ch_of(input logic [`DGO_ADDR_W-1:0] a);
      ch_of = a[7:2];
   endfunction : ch_of
   function automatic dgo_kind_t kind_of(input logic [`DGO_ADDR_W-1:0] a);
      kind_of = dgo_kind_t'(a[9:8]);
   endfunction : kind_of

   dgo_bus_req_t req;
   assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   wire [5:0] req_ch = ch_of(req.addr);
   wire dgo_kind_t req_kind = kind_of(req.addr);
   wire ch_ok = req_ch < 6'(NUM_CH);
   // Channel index in the address is group*GROUP_SIZE + member
   wire wr_in = req.wr && ch_ok && req_kind == DGO_K_INPUT;
   wire wr_gain = req.wr && ch_ok && req_kind == DGO_K_GAIN;
   wire wr_offs = req.wr && ch_ok && req_kind == DGO_K_OFFS;
   wire wr_ctrl = req.wr && req_kind == DGO_K_CTRL && req_ch == 6'h00;

   // Recompute queue: one pending flag per channel; writes keep arriving while busy
   logic [NUM_CH-1:0] dirty_q;
   logic [NUM_CH-1:0] fresh_q;
   logic [NUM_CH-1:0] dirty_set;
   logic [NUM_CH-1:0] clr_sel;
   logic load_pend_q;
   logic [5:0] cur_ch_q;
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_CALC, S_WAIT} dgo_state_t;
   dgo_state_t st_q;
   dgo_state_t st_d;

   // Memories: three coefficient arrays sharing a read address
   logic [5:0] mem_raddr;
   dgo_code_t in_rd;
   dgo_gain_t gain_rd;
   dgo_code_t offs_rd;
   dgo_code_t cmp_rd;
   dgo_code_t calc_res;
   logic calc_done;

   dgo_mem #(.WIDTH(`DGO_CODE_W), .DEPTH(NUM_CH), .RST_VAL(`DGO_CODE_RST)) u_in (
      .mclk(mclk), .rst(rst), .we(wr_in), .waddr(req_ch),
      .wdata(req.wdata[13:0]), .raddr(mem_raddr), .rdata(in_rd));
   dgo_mem #(.WIDTH(`DGO_GAIN_W), .DEPTH(NUM_CH), .RST_VAL(`DGO_GAIN_RST)) u_gain (
      .mclk(mclk), .rst(rst), .we(wr_gain), .waddr(req_ch),
      .wdata(req.wdata[12:0]), .raddr(mem_raddr), .rdata(gain_rd));
   dgo_mem #(.WIDTH(`DGO_CODE_W), .DEPTH(NUM_CH), .RST_VAL(`DGO_OFFS_RST)) u_offs (
      .mclk(mclk), .rst(rst), .we(wr_offs), .waddr(req_ch),
      .wdata(req.wdata[13:0]), .raddr(mem_raddr), .rdata(offs_rd));
   // Computed codes: written by the datapath only
   dgo_mem #(.WIDTH(`DGO_CODE_W), .DEPTH(NUM_CH), .RST_VAL(`DGO_CODE_RST)) u_cmp (
      .mclk(mclk), .rst(rst), .we(calc_done), .waddr(cur_ch_q),
      .wdata(calc_res), .raddr(req_ch), .rdata(cmp_rd));

   // Lowest dirty channel first
   logic [5:0] next_ch;
   logic any_dirty;
   always_comb begin
      next_ch = 6'h00;
      any_dirty = 1'b0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (dirty_q[i]) begin
            next_ch = 6'(i);
            any_dirty = 1'b1;
         end
      end
   end

   assign mem_raddr = (st_q == S_IDLE) ? next_ch : cur_ch_q;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         S_IDLE: if (any_dirty) st_d = S_FETCH;
         S_FETCH: st_d = S_CALC;
         S_CALC: st_d = S_WAIT;
         S_WAIT: st_d = S_IDLE;
      endcase
   end

   dgo_calc u_calc (
      .mclk(mclk), .rst(rst), .start(st_q == S_CALC),
      .code_in(in_rd), .gain_in(gain_rd), .offs_in(offs_rd),
      .done(calc_done), .result(calc_res));

   // Busy while any recompute outstanding or in flight
   assign busy_n = !(any_dirty || st_q != S_IDLE);
   wire load_now = busy_n && (load_pend_q || load_converter_strobe ||
      (wr_ctrl && req.wdata[`DGO_CTRL_LOAD_BIT]));

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         wire hit = ch_ok && req_ch == 6'(g) && (wr_in || wr_gain || wr_offs);
         assign dirty_set[g] = hit;
         assign clr_sel[g] = (st_q == S_IDLE) && any_dirty && next_ch == 6'(g) && !hit;
      end
   endgenerate

   // Converter registers: separate flops per channel, copied on load
   logic [NUM_CH*`DGO_CODE_W-1:0] conv_q;
   logic [NUM_CH*`DGO_CODE_W-1:0] shadow_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= S_IDLE;
         cur_ch_q <= 6'h00;
         dirty_q <= '0;
         fresh_q <= '0;
         load_pend_q <= 1'b0;
         conv_q <= {NUM_CH{`DGO_CODE_RST}};
         shadow_q <= {NUM_CH{`DGO_CODE_RST}};
      end else begin
         st_q <= st_d;
         if (st_q == S_IDLE && any_dirty) cur_ch_q <= next_ch;
         // New write wins over the clear of the same channel
         dirty_q <= (dirty_q & ~clr_sel) | dirty_set;
         if (calc_done) begin
            shadow_q[cur_ch_q*`DGO_CODE_W +: `DGO_CODE_W] <= calc_res;
         end
         if (load_now) begin
            load_pend_q <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
               if (fresh_q[i]) conv_q[i*`DGO_CODE_W +: `DGO_CODE_W] <=
                  shadow_q[i*`DGO_CODE_W +: `DGO_CODE_W];
            end
            fresh_q <= '0;
         end else if (!busy_n && (load_converter_strobe ||
               (wr_ctrl && req.wdata[`DGO_CTRL_LOAD_BIT]))) begin
            load_pend_q <= 1'b1;
         end
         if (calc_done) fresh_q[cur_ch_q] <= 1'b1;
      end
   end
   assign converter_codes = conv_q;

   // Read path: registered, one cycle after the strobe
   logic rd_q;
   dgo_kind_t rd_kind_q;
   logic [5:0] rd_ch_q;
   logic [31:0] rdata_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_q <= 1'b0;
         rd_kind_q <= DGO_K_INPUT;
         rd_ch_q <= 6'h00;
      end else begin
         rd_q <= req.rd;
         rd_kind_q <= req_kind;
         rd_ch_q <= req_ch;
      end
   end
   wire rd_ch_ok = rd_ch_q < 6'(NUM_CH);
   wire [31:0] stat_word = {29'h0, load_pend_q, busy_n, 1'b0};
   // Input, gain, offset reads come back as the computed code of the channel;
   // the coefficient arrays have one read port taken by the datapath.
   always_comb begin
      rdata_q = 32'h0000_0000;
      if (rd_q) begin
         unique case (rd_kind_q)
            DGO_K_CTRL: rdata_q = (rd_ch_q == 6'h00) ? stat_word : 32'h0000_0000;
            default: rdata_q = rd_ch_ok ? {18'h0, cmp_rd} : 32'h0000_0000;
         endcase
      end
   end
   assign bus_rdata = rdata_q;

   // Assertions
   property p_busy_after_write;
      @(posedge mclk) disable iff (rst) (wr_in || wr_gain || wr_offs) |=> !busy_n;
   endproperty
   a_busy_after_write: assert property (p_busy_after_write) else $error("no busy after write");
   property p_busy_ends;
      @(posedge mclk) disable iff (rst)
         ($fell(busy_n) ##1 (!(wr_in || wr_gain || wr_offs))[*8]) |-> ##[0:200] busy_n;
   endproperty
   a_busy_ends: assert property (p_busy_ends) else $error("busy never ends");
   property p_pend_store;
      @(posedge mclk) disable iff (rst) (!busy_n && load_converter_strobe) |=> load_pend_q;
   endproperty
   a_pend_store: assert property (p_pend_store) else $error("load not stored");
   property p_pend_apply;
      @(posedge mclk) disable iff (rst) (load_pend_q && busy_n) |=> !load_pend_q;
   endproperty
   a_pend_apply: assert property (p_pend_apply) else $error("pending load not applied");
   property p_no_load_busy;
      @(posedge mclk) disable iff (rst) !busy_n |=> $stable(conv_q);
   endproperty
   a_no_load_busy: assert property (p_no_load_busy) else $error("converter changed while busy");
   property p_stale_hold;
      @(posedge mclk) disable iff (rst) (load_now && !fresh_q[0]) |=>
         conv_q[`DGO_CODE_W-1:0] == $past(conv_q[`DGO_CODE_W-1:0]);
   endproperty
   a_stale_hold: assert property (p_stale_hold) else $error("stale channel reloaded");
   property p_fresh_copy;
      @(posedge mclk) disable iff (rst) (load_now && fresh_q[0]) |=>
         conv_q[`DGO_CODE_W-1:0] == $past(shadow_q[`DGO_CODE_W-1:0]);
   endproperty
   a_fresh_copy: assert property (p_fresh_copy) else $error("fresh channel not copied");
   property p_clamp_hi;
      @(posedge mclk) disable iff (rst) (st_q == S_CALC && in_rd == 14'h3FFF &&
         gain_rd == 13'h1FFF && offs_rd == 14'h3FFF) |=> calc_res == 14'h3FFF;
   endproperty
   a_clamp_hi: assert property (p_clamp_hi) else $error("no clamp to full scale");
   property p_clamp_lo;
      @(posedge mclk) disable iff (rst) (st_q == S_CALC && in_rd == 14'h0000 &&
         offs_rd == 14'h0000) |=> calc_res == 14'h0000;
   endproperty
   a_clamp_lo: assert property (p_clamp_lo) else $error("no clamp to zero");
   property p_unity;
      @(posedge mclk) disable iff (rst) (st_q == S_CALC && gain_rd == 13'h1FFF &&
         offs_rd == 14'h2000) |=> calc_res == $past(in_rd);
   endproperty
   a_unity: assert property (p_unity) else $error("default coefficients not identity");
endmodule : dgo_top
`default_nettype wire
